// ==== rtl/qsm_core.sv ====
// Queue occupancy state machine with one registered flag per state
//
// Function
// - Reset is synchronous and active high, and every state flag comes from a flip-flop.
// - There are exactly five states: empty, full, idle, draining and filling.
// - The count is an 8-bit unsigned value that the requester keeps between 0 and 250.
// - Reset puts the machine in the empty state, its default.
// - Empty goes to filling on a write with count not 250, and to idle with no requests.
// - Full goes to draining on any read, and to idle with no requests.
// - Idle goes to empty on read at 0, filling on write, draining on read at nonzero, full on write at 250.
// - Draining goes idle, empty, filling, stays, or full, tested in that order.
// - Filling goes idle, empty, stays, full, or draining, tested in that order.
// - When several conditions hold at once, the earliest listed one wins.
// - Each flag is high exactly while the machine is in its state, so one flag is high at a time.
`timescale 1ns/1ps
module qsm_core
	import qsm_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [qsm_pkg::QSM_CNT_W-1:0] count_i,
	output logic empty_o,
	output logic full_o,
	output logic idle_o,
	output logic drain_o,
	output logic fill_o
);
	import qsm_pkg::*;

	qsm_req_s req;
	qsm_state_e state_q, state_d;
	qsm_flags_s flags_q, flags_d;
	logic no_req, rd_zero, rd_nz, wr_full, wr_nfull;

	assign req = '{push: push_i, pop: pop_i, count: count_i};
	// Count is trusted to stay at or below 250
	assign no_req = !req.push && !req.pop;
	assign rd_zero = req.pop && (req.count == QSM_CNT_ZERO);
	assign rd_nz = req.pop && (req.count != QSM_CNT_ZERO);
	assign wr_full = req.push && (req.count == QSM_CNT_FULL);
	assign wr_nfull = req.push && (req.count != QSM_CNT_FULL);

	// If-chains keep the listed order as priority
	always_comb begin
		state_d = state_q;
		case (state_q)
			QSM_EMPTY: begin
				if (wr_nfull) begin
					state_d = QSM_FILL;
				end else if (no_req) begin
					state_d = QSM_IDLE;
				end
			end
			QSM_FULL: begin
				if (no_req) begin
					state_d = QSM_IDLE;
				end else if (req.pop) begin
					state_d = QSM_DRAIN;
				end
			end
			QSM_IDLE: begin
				// Write at 250 is shadowed by the plain write; kept as listed
				if (rd_zero) begin
					state_d = QSM_EMPTY;
				end else if (req.push) begin
					state_d = QSM_FILL;
				end else if (rd_nz) begin
					state_d = QSM_DRAIN;
				end else if (wr_full) begin
					state_d = QSM_FULL;
				end
			end
			QSM_DRAIN: begin
				if (no_req) begin
					state_d = QSM_IDLE;
				end else if (rd_zero) begin
					state_d = QSM_EMPTY;
				end else if (wr_nfull) begin
					state_d = QSM_FILL;
				end else if (rd_nz) begin
					state_d = QSM_DRAIN;
				end else if (wr_full) begin
					state_d = QSM_FULL;
				end
			end
			QSM_FILL: begin
				if (no_req) begin
					state_d = QSM_IDLE;
				end else if (rd_zero) begin
					state_d = QSM_EMPTY;
				end else if (wr_nfull) begin
					state_d = QSM_FILL;
				end else if (wr_full) begin
					state_d = QSM_FULL;
				end else if (rd_nz) begin
					state_d = QSM_DRAIN;
				end
			end
			default: begin
				state_d = QSM_EMPTY;
			end
		endcase
		if (rst_i) begin
			state_d = QSM_EMPTY;
		end
	end

	// Flags decode the next state so they track state_q with no extra lag
	always_comb begin
		flags_d = '0;
		case (state_d)
			QSM_EMPTY: flags_d.empty = 1'b1;
			QSM_FULL: flags_d.full = 1'b1;
			QSM_IDLE: flags_d.idle = 1'b1;
			QSM_DRAIN: flags_d.drain = 1'b1;
			QSM_FILL: flags_d.fill = 1'b1;
			default: flags_d = qsm_flags_s'(QSM_FLAGS_RST);
		endcase
	end

	// Synchronous active-high reset via state_d
	always_ff @(posedge clk_i) begin
		state_q <= state_d;
		flags_q <= flags_d;
	end

	assign empty_o = flags_q.empty;
	assign full_o = flags_q.full;
	assign idle_o = flags_q.idle;
	assign drain_o = flags_q.drain;
	assign fill_o = flags_q.fill;
endmodule

// ==== shared/qsm_pkg.sv ====
// Package for the queue occupancy state machine: widths, thresholds, states, carriers
package qsm_pkg;
	localparam int unsigned QSM_CNT_W = 8;
	localparam logic [7:0] QSM_CNT_ZERO = 8'h00;
	localparam logic [7:0] QSM_CNT_FULL = 8'hfa;
	localparam logic [4:0] QSM_FLAGS_RST = 5'h01;

	typedef enum logic [2:0] {
		QSM_EMPTY,
		QSM_FULL,
		QSM_IDLE,
		QSM_DRAIN,
		QSM_FILL
	} qsm_state_e;

	typedef struct packed {
		logic push;
		logic pop;
		logic [QSM_CNT_W-1:0] count;
	} qsm_req_s;

	typedef struct packed {
		logic fill;
		logic drain;
		logic idle;
		logic full;
		logic empty;
	} qsm_flags_s;
endpackage

// ==== verif/qsm_chk_assertions.sv ====
// Port assertions for the queue state machine
`timescale 1ns/1ps
module qsm_chk import qsm_pkg::*; (
	input wire logic clk_i, rst_i, push_i, pop_i,
	input wire logic [7:0] count_i,
	input wire logic empty_o, full_o, idle_o, drain_o, fill_o
);
	wire logic z = pop_i && count_i == QSM_CNT_ZERO;
	wire logic f = push_i && count_i == QSM_CNT_FULL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_one_hot: assert property ($onehot({fill_o, drain_o, idle_o, full_o, empty_o}))
		else $error("one-hot");
	chk_rst_empty: assert property (disable iff (1'b0) rst_i |=> empty_o)
		else $error("reset");
	chk_quiet_idle: assert property (!push_i && !pop_i |=> idle_o)
		else $error("idle");
	chk_full_drain: assert property (full_o && pop_i |=> drain_o)
		else $error("drain");
	chk_idle_fill: assert property (idle_o && push_i && !z |=> fill_o)
		else $error("fill");
	chk_zero_empty: assert property (!empty_o && !full_o && z |=> empty_o)
		else $error("empty");
	chk_top_full: assert property ((fill_o || drain_o && !pop_i) && f |=> full_o)
		else $error("full");
	chk_empty_hold: assert property (empty_o && pop_i && !(push_i && !f) |=> empty_o)
		else $error("hold");
endmodule
bind qsm_core qsm_chk u_chk (.*);

// ==== verif/qsm_req_mdl.sv ====
// Request-side model: push, pop and an in-range count
`timescale 1ns/1ps
module qsm_req_mdl (
	input wire logic [15:0] rnd_i,
	output qsm_pkg::qsm_req_s req_o
);
	import qsm_pkg::*;
	// 0 and 250 favoured, since most branches turn on them
	assign req_o = {rnd_i[1:0],
		rnd_i[3] ? {8{rnd_i[2]}} & QSM_CNT_FULL : 8'(rnd_i[15:8] % 251)};
endmodule

// ==== verif/tb.sv ====
// Random bench for the queue state machine
`timescale 1ns/1ps
module tb;
	import qsm_pkg::*;
	logic clk_i = 0, rst_i = 1, empty_o, full_o, idle_o, drain_o, fill_o;
	logic [15:0] r = 16'hd77e;
	logic [4:0] e;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	qsm_req_s q;
	always #2.5 clk_i = ~clk_i;
	qsm_req_mdl MDL (.rnd_i(r), .req_o(q));
	qsm_core DUT (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(q.push),
		.pop_i(q.pop),
		.count_i(q.count),
		.empty_o(empty_o),
		.full_o(full_o),
		.idle_o(idle_o),
		.drain_o(drain_o),
		.fill_o(fill_o)
	);
	// Hand-picked walk after reset: fill, full, drain, idle, empty, then push and pop at 250
	function automatic logic [15:0] corner(int k);
		case (k)
		0: return 16'h0502;
		1: return 16'h000e;
		2: return 16'h000d;
		3: return 16'h000c;
		4: return 16'h0009;
		default: return 16'h000f;
		endcase
	endfunction
	function automatic logic [15:0] lfsr(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Flags {fill, drain, idle, full, empty}; first true condition wins
	function automatic logic [4:0] nxt(logic [4:0] v, qsm_req_s a);
		logic n = !a.push && !a.pop, z = a.pop && a.count == QSM_CNT_ZERO;
		logic p = a.push && a.count != QSM_CNT_FULL;
		case (1'b1)
		v[0]: return p ? 5'h10 : n ? 5'h04 : v;
		v[1]: return n ? 5'h04 : a.pop ? 5'h08 : v;
		v[2]: return z ? 5'h01 : a.push ? 5'h10 : a.pop ? 5'h08 : v;
		default: return n ? 5'h04 : z ? 5'h01 : p ? 5'h10 :
			a.pop && (v[3] || !a.push) ? 5'h08 : a.push ? 5'h02 : v;
		endcase
	endfunction
	task cmp(logic [4:0] a, b);
		n_tests++;
		if (a !== b) begin
			n_mismatch++;
			$display("mismatch %0t %h %h", $time, a, b);
		end
	endtask
	task finish_test;
		$display("%0d mismatches in %0d tests", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i) if (++cyc > 2100) begin
		n_mismatch++;
		finish_test;
	end
	initial begin
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk_i);
			e = rst_i ? QSM_FLAGS_RST : nxt(e, q);
			#1 cmp({fill_o, drain_o, idle_o, full_o, empty_o}, e);
			r = (i >= 19 && i < 25) ? corner(i - 19) : lfsr(r);
			rst_i = i < 19 || i == 999;
		end
		finish_test;
	end
endmodule
